// ===== pkg/rls_pkg.sv
// Constants for the rate and loss-of-signal setting select bank
`default_nettype none
package rls_pkg;
  // Register indices on the parallel register port
  localparam logic [3:0] RLS_ADDR_BW_A  = 4'h0;
  localparam logic [3:0] RLS_ADDR_BW_B  = 4'h1;
  localparam logic [3:0] RLS_ADDR_BW_C  = 4'h2;
  localparam logic [3:0] RLS_ADDR_BW_D  = 4'h3;
  localparam logic [3:0] RLS_ADDR_LOS_A = 4'h4;
  localparam logic [3:0] RLS_ADDR_LOS_B = 4'h5;
  localparam logic [3:0] RLS_ADDR_LOS_C = 4'h6;
  localparam logic [3:0] RLS_ADDR_LOS_D = 4'h7;
  localparam logic [3:0] RLS_ADDR_RB_BW = 4'h8;
  localparam logic [3:0] RLS_ADDR_RB_LOS = 4'h9;

  // Field layout
  localparam int RLS_SEL_BIT = 7;
  localparam int RLS_BW_W    = 4;
  localparam int RLS_LOS_W   = 7;

  localparam logic [7:0] RLS_REG_RESET = 8'h00;

  // Rate slot index A..D
  localparam logic [1:0] RLS_SLOT_A = 2'h0;
  localparam logic [1:0] RLS_SLOT_B = 2'h1;
  localparam logic [1:0] RLS_SLOT_C = 2'h2;
  localparam logic [1:0] RLS_SLOT_D = 2'h3;

  // Built-in default codes: 2.4, 7.6, 8.4, 9.0 GHz bandwidth
  localparam logic [3:0] RLS_BW_DEF_A = 4'h1;
  localparam logic [3:0] RLS_BW_DEF_B = 4'h6;
  localparam logic [3:0] RLS_BW_DEF_C = 4'h8;
  localparam logic [3:0] RLS_BW_DEF_D = 4'hA;
  // Built-in default codes: 15, 18, 26, 26 mVpp LOS assert level
  localparam logic [6:0] RLS_LOS_DEF_A = 7'h0F;
  localparam logic [6:0] RLS_LOS_DEF_B = 7'h12;
  localparam logic [6:0] RLS_LOS_DEF_C = 7'h1A;
  localparam logic [6:0] RLS_LOS_DEF_D = 7'h1A;
endpackage
`default_nettype wire

// ===== verilog/rls_pick.sv
// Chooses register field or built-in default by the select bit
`timescale 1ns/1ns
`default_nettype none
module rls_pick
  import rls_pkg::*;
#(
  parameter int W = 4
) (
  input  wire logic [7:0]   reg_value,
  input  wire logic [W-1:0] default_code,
  output logic      [W-1:0] code
);
  assign code = reg_value[RLS_SEL_BIT] ? reg_value[W-1:0] : default_code;
endmodule
`default_nettype wire

// ===== verilog/rls_setting_select.sv
// Rate bandwidth and LOS level select register bank with readback
`timescale 1ns/1ns
`default_nettype none
module rls_setting_select
  import rls_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       rate_pin_upper,
  input  wire logic       rate_pin_lower,
  input  wire logic       rate_pins_open,
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rd_data,
  output logic      [3:0] active_bw_code,
  output logic      [6:0] active_los_code
);

  // Pins in Gray order 00 A, 01 B, 11 C, 10 D; unconnected pins fall back to slot D
  function automatic logic [1:0] rls_slot(input logic up, input logic lo, input logic open);
    if (open) begin
      return RLS_SLOT_D;
    end
    return {up, up ^ lo};
  endfunction

  logic [7:0] bw_reg [4];
  logic [7:0] los_reg [4];
  logic [3:0] bw_pick [4];
  logic [6:0] los_pick [4];
  logic [1:0] slot;
  logic [3:0] next_bw;
  logic [6:0] next_los;

  localparam logic [3:0] BW_DEF [4] = '{RLS_BW_DEF_A, RLS_BW_DEF_B, RLS_BW_DEF_C, RLS_BW_DEF_D};
  localparam logic [6:0] LOS_DEF [4] = '{RLS_LOS_DEF_A, RLS_LOS_DEF_B, RLS_LOS_DEF_C,
                                        RLS_LOS_DEF_D};

  // Writable setting registers; readback indices have no storage to write
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_slot
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          bw_reg[gi]  <= RLS_REG_RESET;
          los_reg[gi] <= RLS_REG_RESET;
        end else if (reg_wr_en) begin
          if (reg_addr == RLS_ADDR_BW_A + 4'(gi)) begin
            bw_reg[gi] <= reg_wr_data;
          end
          if (reg_addr == RLS_ADDR_LOS_A + 4'(gi)) begin
            los_reg[gi] <= reg_wr_data;
          end
        end
      end

      rls_pick #(.W(RLS_BW_W)) u_bw_pick (
        .reg_value    (bw_reg[gi]),
        .default_code (BW_DEF[gi]),
        .code         (bw_pick[gi])
      );

      rls_pick #(.W(RLS_LOS_W)) u_los_pick (
        .reg_value    (los_reg[gi]),
        .default_code (LOS_DEF[gi]),
        .code         (los_pick[gi])
      );
    end
  endgenerate

  // Pin-driven slot selection
  always_comb begin
    slot     = rls_slot(rate_pin_upper, rate_pin_lower, rate_pins_open);
    next_bw  = bw_pick[slot];
    next_los = los_pick[slot];
  end

  // Values in force, passed unaltered so the code order stays monotonic
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_bw_code  <= RLS_BW_DEF_A;
      active_los_code <= RLS_LOS_DEF_A;
    end else begin
      active_bw_code  <= next_bw;
      active_los_code <= next_los;
    end
  end

  // Read port, one cycle latency; unmapped indices read zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        RLS_ADDR_BW_A, RLS_ADDR_BW_B, RLS_ADDR_BW_C, RLS_ADDR_BW_D:
          reg_rd_data <= bw_reg[reg_addr[1:0]];
        RLS_ADDR_LOS_A, RLS_ADDR_LOS_B, RLS_ADDR_LOS_C, RLS_ADDR_LOS_D:
          reg_rd_data <= los_reg[reg_addr[1:0]];
        RLS_ADDR_RB_BW:  reg_rd_data <= {4'h0, active_bw_code};
        RLS_ADDR_RB_LOS: reg_rd_data <= {1'h0, active_los_code};
        default:         reg_rd_data <= 8'h00;
      endcase
    end
  end

  a_bw_c_used: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rate_pin_upper && rate_pin_lower && !rate_pins_open && bw_reg[2][7])
    |=> active_bw_code == $past(bw_reg[2][3:0]))
    else $error("bandwidth C field not applied");

  a_bw_c_default: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rate_pin_upper && rate_pin_lower && !rate_pins_open && !bw_reg[2][7])
    |=> active_bw_code == RLS_BW_DEF_C)
    else $error("bandwidth C default not applied");

  a_bw_d_open: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rate_pins_open |=> active_bw_code == ($past(bw_reg[3][7]) ? $past(bw_reg[3][3:0])
                                          : RLS_BW_DEF_D))
    else $error("open pins did not select bandwidth D");

  a_bw_d_pins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rate_pin_upper && !rate_pin_lower && !bw_reg[3][7]) |=> active_bw_code == RLS_BW_DEF_D)
    else $error("bandwidth D default not applied");

  a_los_a_slot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pin_upper && !rate_pin_lower && !rate_pins_open)
    |=> active_los_code == ($past(los_reg[0][7]) ? $past(los_reg[0][6:0]) : RLS_LOS_DEF_A))
    else $error("LOS A not selected");

  a_los_b_slot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pin_upper && rate_pin_lower && !rate_pins_open && !los_reg[1][7])
    |=> active_los_code == RLS_LOS_DEF_B)
    else $error("LOS B default not applied");

  a_los_c_slot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rate_pin_upper && rate_pin_lower && !rate_pins_open && los_reg[2][7])
    |=> active_los_code == $past(los_reg[2][6:0]))
    else $error("LOS C field not applied");

  a_bw_b_slot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pin_upper && rate_pin_lower && !rate_pins_open && !bw_reg[1][7])
    |=> active_bw_code == RLS_BW_DEF_B)
    else $error("bandwidth B default not applied");

  a_rb_bw_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_rd_en && reg_addr == RLS_ADDR_RB_BW) |=> reg_rd_data == {4'h0, $past(active_bw_code)})
    else $error("bandwidth readback wrong");

  a_rb_los_read: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_rd_en && reg_addr == RLS_ADDR_RB_LOS)
    |=> reg_rd_data == {1'h0, $past(active_los_code)})
    else $error("LOS readback wrong");

  a_rb_wr_ignored: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr[3])
    |=> (bw_reg[0] == $past(bw_reg[0]) && bw_reg[1] == $past(bw_reg[1]) &&
         bw_reg[2] == $past(bw_reg[2]) && bw_reg[3] == $past(bw_reg[3]) &&
         los_reg[0] == $past(los_reg[0]) && los_reg[1] == $past(los_reg[1]) &&
         los_reg[2] == $past(los_reg[2]) && los_reg[3] == $past(los_reg[3])))
    else $error("readback write changed storage");

  // Bandwidth slots A field and default, B field, D field and open-pin default
  a_bw_a_field: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pin_upper && !rate_pin_lower && !rate_pins_open && bw_reg[0][7])
    |=> active_bw_code == $past(bw_reg[0][3:0]))
    else $error("bandwidth A field not applied");

  a_bw_a_default: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pin_upper && !rate_pin_lower && !rate_pins_open && !bw_reg[0][7])
    |=> active_bw_code == RLS_BW_DEF_A)
    else $error("bandwidth A default not applied");

  a_bw_b_field: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pin_upper && rate_pin_lower && !rate_pins_open && bw_reg[1][7])
    |=> active_bw_code == $past(bw_reg[1][3:0]))
    else $error("bandwidth B field not applied");

  a_bw_d_field: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rate_pin_upper && !rate_pin_lower && bw_reg[3][7])
    |=> active_bw_code == $past(bw_reg[3][3:0]))
    else $error("bandwidth D field not applied");

  a_bw_d_unwired: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rate_pins_open && !bw_reg[3][7])
    |=> active_bw_code == RLS_BW_DEF_D)
    else $error("bandwidth D default not applied on open pins");

  // Loss-of-signal slots, field and default
  a_los_a_field: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pin_upper && !rate_pin_lower && !rate_pins_open && los_reg[0][7])
    |=> active_los_code == $past(los_reg[0][6:0]))
    else $error("LOS A field not applied");

  a_los_a_default: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pin_upper && !rate_pin_lower && !rate_pins_open && !los_reg[0][7])
    |=> active_los_code == RLS_LOS_DEF_A)
    else $error("LOS A default not applied");

  a_los_b_field: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pin_upper && rate_pin_lower && !rate_pins_open && los_reg[1][7])
    |=> active_los_code == $past(los_reg[1][6:0]))
    else $error("LOS B field not applied");

  a_los_c_default: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rate_pin_upper && rate_pin_lower && !rate_pins_open && !los_reg[2][7])
    |=> active_los_code == RLS_LOS_DEF_C)
    else $error("LOS C default not applied");

  a_los_d_field: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rate_pin_upper && !rate_pin_lower && los_reg[3][7])
    |=> active_los_code == $past(los_reg[3][6:0]))
    else $error("LOS D field not applied");

  a_los_d_default: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rate_pin_upper && !rate_pin_lower && !los_reg[3][7])
    |=> active_los_code == RLS_LOS_DEF_D)
    else $error("LOS D default not applied");

  a_los_d_open: assert property (@(posedge ref_clk) disable iff (!rst_b)
    rate_pins_open
    |=> active_los_code == ($past(los_reg[3][7]) ? $past(los_reg[3][6:0]) : RLS_LOS_DEF_D))
    else $error("open pins did not select LOS D");

  // Slot decode, both directions
  a_slot_a_pins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (slot == RLS_SLOT_A)
    |-> (!rate_pins_open && !rate_pin_upper && !rate_pin_lower))
    else $error("slot A taken for other pins");

  a_pins_a_slot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pins_open && !rate_pin_upper && !rate_pin_lower)
    |-> (slot == RLS_SLOT_A))
    else $error("pins 00 did not select slot A");

  a_slot_b_pins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (slot == RLS_SLOT_B)
    |-> (!rate_pins_open && !rate_pin_upper && rate_pin_lower))
    else $error("slot B taken for other pins");

  a_pins_b_slot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pins_open && !rate_pin_upper && rate_pin_lower)
    |-> (slot == RLS_SLOT_B))
    else $error("pins 01 did not select slot B");

  a_slot_c_pins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (slot == RLS_SLOT_C)
    |-> (!rate_pins_open && rate_pin_upper && rate_pin_lower))
    else $error("slot C taken for other pins");

  a_pins_c_slot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!rate_pins_open && rate_pin_upper && rate_pin_lower)
    |-> (slot == RLS_SLOT_C))
    else $error("pins 11 did not select slot C");

  a_slot_d_pins: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (slot == RLS_SLOT_D)
    |-> (rate_pins_open || (rate_pin_upper && !rate_pin_lower)))
    else $error("slot D taken for other pins");

  a_pins_d_slot: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (rate_pins_open || (rate_pin_upper && !rate_pin_lower))
    |-> (slot == RLS_SLOT_D))
    else $error("pins 10 or open did not select slot D");

  // Register port storage and read path
  a_bw_wr_lands: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr[3:2] == RLS_ADDR_BW_A[3:2])
    |=> bw_reg[$past(reg_addr[1:0])] == $past(reg_wr_data))
    else $error("bandwidth register write lost");

  a_los_wr_lands: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr_en && reg_addr[3:2] == RLS_ADDR_LOS_A[3:2])
    |=> los_reg[$past(reg_addr[1:0])] == $past(reg_wr_data))
    else $error("LOS register write lost");

  a_rd_bw_reg: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_rd_en && reg_addr[3:2] == RLS_ADDR_BW_A[3:2])
    |=> reg_rd_data == $past(bw_reg[reg_addr[1:0]]))
    else $error("bandwidth register read wrong");

  a_rd_los_reg: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_rd_en && reg_addr[3:2] == RLS_ADDR_LOS_A[3:2])
    |=> reg_rd_data == $past(los_reg[reg_addr[1:0]]))
    else $error("LOS register read wrong");

  a_rd_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_rd_en && reg_addr > RLS_ADDR_RB_LOS)
    |=> reg_rd_data == 8'h00)
    else $error("unmapped index read nonzero");

  a_rd_wr_stands: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_wr_en && !reg_rd_en)
    |=> $stable(reg_rd_data))
    else $error("write disturbed read data");

  a_rd_idle_stands: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !reg_rd_en
    |=> $stable(reg_rd_data))
    else $error("read data changed without a read");
endmodule
`default_nettype wire

// ===== tb/rls_host.sv
// Host controller model driving the register port
`timescale 1ns/1ns
`default_nettype none
module rls_host (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rd_data,
  output logic      [3:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en
);
  initial begin
    reg_addr = 4'h0;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end

  // One write or read cycle; read data is taken after the read edge
  task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= wr;
    reg_rd_en <= !wr;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    // Released lines do not keep their last value
    reg_addr <= ~a;
    reg_wr_data <= ~d;
    @(negedge ref_clk);
    q = reg_rd_data;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the setting select register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import rls_pkg::*;
;
  logic       ref_clk, rst_b, rate_pin_upper, rate_pin_lower, rate_pins_open;
  logic [3:0] reg_addr;
  logic       reg_wr_en, reg_rd_en;
  logic [7:0] reg_wr_data, reg_rd_data, q;
  logic [3:0] active_bw_code;
  logic [6:0] active_los_code;
  logic [7:0] regs [8];
  logic [3:0] bw_def [4] = '{RLS_BW_DEF_A, RLS_BW_DEF_B, RLS_BW_DEF_C, RLS_BW_DEF_D};
  logic [6:0] los_def [4] = '{RLS_LOS_DEF_A, RLS_LOS_DEF_B, RLS_LOS_DEF_C, RLS_LOS_DEF_D};
  int         mismatches, n_tests;

  rls_setting_select dut (.ref_clk, .rst_b, .rate_pin_upper, .rate_pin_lower,
    .rate_pins_open, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en,
    .reg_rd_data, .active_bw_code, .active_los_code);
  rls_host host (.ref_clk, .reg_rd_data, .reg_addr, .reg_wr_en, .reg_wr_data,
    .reg_rd_en);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Rate slot from the pins: 00=A 01=B 11=C 10=D, unconnected pins give D
  function automatic int slot();
    if (rate_pins_open)
      return 3;
    return {rate_pin_upper, rate_pin_lower} == 2'b11 ? 2 :
           {rate_pin_upper, rate_pin_lower} == 2'b10 ? 3 : int'(rate_pin_lower);
  endfunction

  function automatic logic [7:0] exp_bw();
    int s = slot();
    return regs[s][7] ? {4'h0, regs[s][3:0]} : {4'h0, bw_def[s]};
  endfunction

  function automatic logic [7:0] exp_los();
    int s = slot();
    return regs[s+4][7] ? {1'b0, regs[s+4][6:0]} : {1'b0, los_def[s]};
  endfunction

  initial begin
    logic [3:0] a;
    logic [7:0] d;
    void'($urandom(32'h36489F16));
    rst_b = 1'b0;
    rate_pin_upper = 1'b0;
    rate_pin_lower = 1'b0;
    rate_pins_open = 1'b0;
    foreach (regs[i]) regs[i] = RLS_REG_RESET;
    repeat (3) @(posedge ref_clk);
    chk(active_bw_code, RLS_BW_DEF_A);
    chk(active_los_code, RLS_LOS_DEF_A);
    rst_b <= 1'b1;
    for (int it = 0; it < 400; it++) begin
      @(posedge ref_clk);
      if (it == 200) begin
        // Mid-run reset with pins parked on slot A, whose defaults match the reset codes
        rst_b <= 1'h0;
        rate_pin_upper <= 1'h0;
        rate_pin_lower <= 1'h0;
        rate_pins_open <= 1'h0;
        @(negedge ref_clk);
        chk(active_bw_code, RLS_BW_DEF_A);
        chk(active_los_code, RLS_LOS_DEF_A);
        foreach (regs[k]) regs[k] = RLS_REG_RESET;
        @(posedge ref_clk);
        rst_b <= 1'h1;
      end
      rate_pin_upper <= 1'($urandom);
      rate_pin_lower <= 1'($urandom);
      rate_pins_open <= ($urandom_range(7) == 0);
      a = 4'($urandom);
      d = 8'($urandom);
      host.access(1'b1, a, d, q);
      if (a < 4'h8)
        regs[a[2:0]] = d;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(active_bw_code, exp_bw());
      chk(active_los_code, exp_los());
      host.access(1'b0, RLS_ADDR_RB_BW, 8'h00, q);
      chk(q, exp_bw());
      host.access(1'b0, RLS_ADDR_RB_LOS, 8'h00, q);
      chk(q, exp_los());
      host.access(1'b0, a, 8'h00, q);
      chk(q, a < 4'h8 ? regs[a[2:0]] : a == RLS_ADDR_RB_BW ? exp_bw() :
             a == RLS_ADDR_RB_LOS ? exp_los() : 8'h00);
    end
    close_out();
  end
endmodule
`default_nettype wire
